// *** rtl/p6m_port.sv ***
`timescale 1ns/1ps
// eight-pin port with control-function multiplexing, wishbone registers
module p6m_port
  import p6m_pkg::*;
#(
  parameter bit REDUCED_VARIANT = 1'b0 // fixed strobes, output-only 0-3
) (
  input wire logic clk_i, // 20 MHz system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic ext_space_i, // current access above internal range
  input wire logic [3:0] ext_addr_hi_i, // high address bits of access
  input wire logic ext_rd_i, // external read in progress
  input wire logic ext_wr_i, // external write in progress
  input wire logic hold_ack_i, // bus released to external master
  input wire logic refresh_pulse_i, // refresh pulse from timer
  output logic bus_hold_request_o, // synced hold request
  output logic ext_wait_o, // synced wait request
  input wire logic [7:0] port_pins_i, // pin levels
  output logic [7:0] port_pins_o, // pin drive values
  output logic [7:0] port_pins_oe_o, // pin drive enables
  output logic [7:0] port_pullup_o // pull-up enables
);
  p6m_sel_if sif(); // link to the function selector

  logic [7:0] latch; // output latches
  logic [7:0] port_dir_reg; // 1 = input
  logic [3:0] mem_ext_mode_reg; // mode field
  logic [7:0] pullup_option_reg; // pull-up option
  logic [7:0] hold_mode_reg; // hold mode
  logic [7:0] refresh_mode_reg; // refresh mode
  logic [7:0] wait_ctrl_reg_a; // regions 0-3
  logic [7:0] wait_ctrl_reg_b; // regions 4-7
  logic [7:0] pin_meta; // first sync stage
  logic [7:0] pin_sync; // second sync stage
  logic [7:0] out_only; // pins without input function
  logic [7:0] next_oe; // next drive enables
  logic [7:0] next_out; // next drive values
  logic [7:0] next_pu; // next pull-ups
  logic [7:0] port_rd; // software view of the port
  logic [7:0] next_rdata; // decoded read data
  logic wr_en; // write accepted this edge
  logic [7:0] wdata; // low byte of write data

  // feed the function selector
  assign sif.mode = mem_ext_mode_reg;
  assign sif.dir = port_dir_reg;
  assign sif.wait_ctrl = {wait_ctrl_reg_b, wait_ctrl_reg_a};
  assign sif.hold_en = hold_mode_reg[P6M_HOLD_EN_BIT];
  assign sif.refr_en = refresh_mode_reg[P6M_REFR_EN_BIT];
  assign sif.reduced = REDUCED_VARIANT;
  assign sif.ext_space = ext_space_i;
  assign sif.ext_rd = ext_rd_i;
  assign sif.ext_wr = ext_wr_i;
  assign sif.addr_hi = ext_addr_hi_i;
  assign sif.hold_ack = hold_ack_i;
  assign sif.refr_pulse = refresh_pulse_i;

  p6m_func_sel u_sel (
    .s(sif.sel)
  );

  // reduced variant: pins 0-3 are output-only
  assign out_only = REDUCED_VARIANT ? 8'h0F : 8'h00; // [R13]

  // write happens at the edge where ack is seen by the master
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign wdata = wb_dat_i[7:0];

  // two-stage synchroniser for the pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      pin_meta <= port_pins_i;
      pin_sync <= pin_meta;
    end
  end

  // output latches; control pins keep their old content
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch <= P6M_LATCH_RST; // reduced 0-3 start low [R14]
    end else if (wr_en && wb_adr_i == P6M_OFF_DATA) begin
      latch <= (wdata & ~sif.ctrl_mask) | (latch & sif.ctrl_mask); // [R16] [R17]
    end
  end

  // direction register, all inputs after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_dir_reg <= P6M_DIR_RST; // [R1]
    end else if (wr_en && wb_adr_i == P6M_OFF_DIR) begin
      port_dir_reg <= wdata; // [R11]
    end
  end

  // mode and option registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_ext_mode_reg <= P6M_MODE_RST;
      pullup_option_reg <= P6M_REG_RST;
      hold_mode_reg <= P6M_REG_RST;
      refresh_mode_reg <= P6M_REG_RST;
      wait_ctrl_reg_a <= P6M_REG_RST;
      wait_ctrl_reg_b <= P6M_REG_RST;
    end else if (wr_en) begin
      unique case (wb_adr_i)
        P6M_OFF_MODE: begin
          mem_ext_mode_reg <= wdata[3:0]; // [R2]
        end
        P6M_OFF_PUO: begin
          pullup_option_reg <= wdata; // [R15]
        end
        P6M_OFF_HOLD: begin
          hold_mode_reg <= wdata; // [R8]
        end
        P6M_OFF_REFR: begin
          refresh_mode_reg <= wdata; // [R10]
        end
        P6M_OFF_WAITA: begin
          wait_ctrl_reg_a <= wdata; // [R7]
        end
        P6M_OFF_WAITB: begin
          wait_ctrl_reg_b <= wdata; // [R7]
        end
        default: begin
          // data, direction or unmapped: nothing here
        end
      endcase
    end
  end

  // per-pin drive, pull-up and software view
  genvar p;
  generate
    for (p = 0; p < P6M_PINS; p++) begin : g_pin
      logic is_in; // port-mode input
      assign is_in = port_dir_reg[p] && !out_only[p]; // [R11] [R13]
      // control function overrides direction and latch
      assign next_oe[p] = sif.ctrl_mask[p] ? sif.ctrl_oe[p] : !is_in; // [R18] [R11]
      assign next_out[p] = sif.ctrl_mask[p] ? sif.ctrl_val[p] : latch[p]; // [R18] [R16]
      // pull-up on pins set as input by direction, even when a control function drives them; never on output-only ones
      assign next_pu[p] = pullup_option_reg[P6M_PUO_BIT] && is_in; // [R15] [R12]
      // control pins read as zero, inputs read the pin
      assign port_rd[p] = sif.ctrl_mask[p] ? 1'b0 : (is_in ? pin_sync[p] : latch[p]); // [R17]
    end
  endgenerate

  // registered pin outputs, drivers off during reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_pins_oe_o <= 8'h00; // [R1] [R14]
      port_pins_o <= 8'h00;
      port_pullup_o <= 8'h00;
    end else begin
      port_pins_oe_o <= next_oe;
      port_pins_o <= next_out;
      port_pullup_o <= next_pu;
    end
  end

  // inputs toward the bus controller
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_hold_request_o <= 1'b0;
      ext_wait_o <= 1'b0;
    end else begin
      bus_hold_request_o <= sif.hold_en && pin_sync[P6M_PIN_IN]; // [R8]
      ext_wait_o <= sif.wait_en && !pin_sync[P6M_PIN_IN]; // low pin stretches [R7]
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = 8'h00;
    unique case (wb_adr_i)
      P6M_OFF_DATA: begin
        next_rdata = port_rd; // [R17]
      end
      P6M_OFF_DIR: begin
        next_rdata = port_dir_reg;
      end
      P6M_OFF_MODE: begin
        next_rdata = {4'h0, mem_ext_mode_reg};
      end
      P6M_OFF_PUO: begin
        next_rdata = pullup_option_reg;
      end
      P6M_OFF_HOLD: begin
        next_rdata = hold_mode_reg;
      end
      P6M_OFF_REFR: begin
        next_rdata = refresh_mode_reg;
      end
      P6M_OFF_WAITA: begin
        next_rdata = wait_ctrl_reg_a;
      end
      P6M_OFF_WAITB: begin
        next_rdata = wait_ctrl_reg_b;
      end
      default: begin
        next_rdata = 8'h00; // unmapped
      end
    endcase
  end

  // wishbone answer: ack one cycle after the request, for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= {24'h00_0000, next_rdata};
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_hold_on;
    sif.hold_en[*4];
  endsequence

  sequence s_wait_on;
    sif.wait_en[*4];
  endsequence

  a_reset_inputs: assert property (disable iff (1'b0) // [R1]
    rst_i |=> (port_pins_oe_o == 8'h00) && (port_dir_reg == P6M_DIR_RST))
    else $error("pins not released at reset");
  a_addr_pairs: assert property ((mem_ext_mode_reg == P6M_MM_ADDR2) && ext_space_i // [R2]
    && !REDUCED_VARIANT |=> port_pins_oe_o[1:0] == 2'h3 && port_pins_o[1:0]
    == $past(ext_addr_hi_i[1:0]) && port_pins_oe_o[3:2] == ~$past(port_dir_reg[3:2]))
    else $error("address pair mapping wrong");
  a_addr_gate: assert property ((mem_ext_mode_reg == P6M_MM_ADDR4) && !ext_space_i // [R3]
    && !REDUCED_VARIANT |=> port_pins_oe_o[3:0] == 4'h0)
    else $error("address lines driven outside extended space");
  // reset is in the antecedent: the release edge still loads reset values
  a_rd_strobe: assert property (!rst_i && sif.ctrl_mask[P6M_PIN_RD] |=> // [R5]
    port_pins_oe_o[P6M_PIN_RD] && port_pins_o[P6M_PIN_RD] == !$past(ext_rd_i))
    else $error("read strobe wrong");
  a_wr_strobe: assert property ((mem_ext_mode_reg == P6M_MM_STRB_MIN) |=> // [R6] [R4]
    port_pins_oe_o[P6M_PIN_WR] && port_pins_o[P6M_PIN_WR] == !$past(ext_wr_i))
    else $error("write strobe wrong");
  a_wait_input: assert property (s_wait_on |-> // [R7]
    ext_wait_o == !$past(port_pins_i[P6M_PIN_IN], 3) && !port_pins_oe_o[P6M_PIN_IN])
    else $error("wait input not followed");
  a_hold_request: assert property (s_hold_on |-> // [R8]
    bus_hold_request_o == $past(port_pins_i[P6M_PIN_IN], 3))
    else $error("hold request not followed");
  a_hold_ack: assert property (sif.hold_en |=> // [R9]
    port_pins_oe_o[P6M_PIN_OUT] && port_pins_o[P6M_PIN_OUT] == $past(hold_ack_i))
    else $error("hold acknowledge wrong");
  a_refresh_out: assert property (!sif.hold_en && sif.refr_en |=> // [R10]
    port_pins_o[P6M_PIN_OUT] == $past(refresh_pulse_i))
    else $error("refresh output wrong");
  // expected from option bit and direction; reduced pins 0-3 never pull up
  a_pullup_dir: assert property (1'b1 |=> port_pullup_o // [R15]
    == ({8{$past(pullup_option_reg[P6M_PUO_BIT])}} & $past(port_dir_reg)
    & (REDUCED_VARIANT ? 8'hF0 : 8'hFF)))
    else $error("pull-up wrong");
  a_ctrl_hidden: assert property (wb_ack_o && !wb_we_i && $past(wb_adr_i) // [R17]
    == P6M_OFF_DATA |-> (wb_dat_o[7:0] & $past(sif.ctrl_mask)) == 8'h00)
    else $error("control pin visible to software");
  a_reduced_low: assert property (REDUCED_VARIANT && $fell(rst_i) |-> // [R14]
    port_pins_oe_o[3:0] == 4'h0 ##1 port_pins_oe_o[3:0] == 4'hF)
    else $error("reduced pins not driven after reset");
endmodule

// *** rtl/p6m_pkg.sv ***
// Overview of operation
// (R1) reset: all pins input, drivers off
// (R2) mode field maps pins 0-3 to upper address pairs
// (R3) address lines driven only for extended space
// (R4) pins 4,5 become strobes in extension modes
// (R5) read strobe low during external reads
// (R6) write strobe low during external writes
// (R7) pin 6 wait input when selected and input
// (R8) hold enable makes pin 6 hold request
// (R9) hold enable makes pin 7 hold acknowledge
// (R10) refresh enable makes pin 7 refresh output
// (R11) free pins follow direction register bitwise
// (R12) eight latches, switchable pull-ups
// (R13) reduced: strobes fixed, pins 0-3 output-only
// (R14) reduced: pins 0-3 float in reset, then low
// (R15) pull-up option enables pull-ups on inputs
// (R16) port write updates all free latches
// (R17) control pins hidden from software
// (R18) control function overrides direction and latch
package p6m_pkg;
  localparam int unsigned P6M_PINS = 8; // port width
  localparam int unsigned P6M_WAIT_REGIONS = 8; // wait regions
  // register byte offsets
  localparam logic [7:0] P6M_OFF_DATA = 8'h00; // port data
  localparam logic [7:0] P6M_OFF_DIR = 8'h04; // port_dir_reg
  localparam logic [7:0] P6M_OFF_MODE = 8'h08; // mem_ext_mode_reg
  localparam logic [7:0] P6M_OFF_PUO = 8'h0C; // pullup_option_reg
  localparam logic [7:0] P6M_OFF_HOLD = 8'h10; // hold_mode_reg
  localparam logic [7:0] P6M_OFF_REFR = 8'h14; // refresh_mode_reg
  localparam logic [7:0] P6M_OFF_WAITA = 8'h18; // wait_ctrl_reg_a
  localparam logic [7:0] P6M_OFF_WAITB = 8'h1C; // wait_ctrl_reg_b
  // reset values
  localparam logic [7:0] P6M_DIR_RST = 8'hFF; // all inputs
  localparam logic [7:0] P6M_LATCH_RST = 8'h00; // latch cleared
  localparam logic [7:0] P6M_REG_RST = 8'h00; // other registers
  localparam logic [3:0] P6M_MODE_RST = 4'h0; // port mode
  // memory extension mode codes
  localparam logic [3:0] P6M_MM_STRB_MIN = 4'h4; // first strobe code
  localparam logic [3:0] P6M_MM_ADDR2 = 4'h8; // A16..A17
  localparam logic [3:0] P6M_MM_ADDR4 = 4'h9; // A16..A19, last legal
  // pin positions
  localparam int unsigned P6M_PIN_RD = 4; // read strobe
  localparam int unsigned P6M_PIN_WR = 5; // write strobe
  localparam int unsigned P6M_PIN_IN = 6; // wait or hold request
  localparam int unsigned P6M_PIN_OUT = 7; // hold ack or refresh
  localparam int unsigned P6M_ADDR_PAIR = 2; // address pins per pair
  // control bit positions
  localparam int unsigned P6M_HOLD_EN_BIT = 0; // hold_enable_bit
  localparam int unsigned P6M_REFR_EN_BIT = 0; // refresh_enable_bit
  localparam int unsigned P6M_PUO_BIT = 6; // port_pullup_enable
  localparam logic [1:0] P6M_WAIT_EXT = 2'h3; // region uses pin wait
endpackage

// *** rtl/p6m_sel_if.sv ***
`timescale 1ns/1ps
// configuration and bus activity in, per-pin control functions out
interface p6m_sel_if;
  logic [3:0] mode; // mem_ext_mode_field
  logic [7:0] dir; // port_dir_reg
  logic [15:0] wait_ctrl; // wait_ctrl_reg_b & wait_ctrl_reg_a
  logic hold_en; // hold_enable_bit
  logic refr_en; // refresh_enable_bit
  logic reduced; // reduced variant
  logic ext_space; // access above internal range
  logic ext_rd; // external read in progress
  logic ext_wr; // external write in progress
  logic [3:0] addr_hi; // upper address bits
  logic hold_ack; // bus released
  logic refr_pulse; // refresh pulse
  logic [7:0] ctrl_mask; // pin owned by a control function
  logic [7:0] ctrl_oe; // control drive enable
  logic [7:0] ctrl_val; // control drive value
  logic wait_en; // pin 6 is wait input
  modport sel (input mode, dir, wait_ctrl, hold_en, refr_en, reduced, ext_space,
    ext_rd, ext_wr, addr_hi, hold_ack, refr_pulse,
    output ctrl_mask, ctrl_oe, ctrl_val, wait_en);
  modport top (output mode, dir, wait_ctrl, hold_en, refr_en, reduced, ext_space,
    ext_rd, ext_wr, addr_hi, hold_ack, refr_pulse,
    input ctrl_mask, ctrl_oe, ctrl_val, wait_en);
endinterface

// *** rtl/p6m_func_sel.sv ***
`timescale 1ns/1ps
// decides which pins carry a control function and what they drive
module p6m_func_sel
  import p6m_pkg::*;
(
  p6m_sel_if.sel s // configuration in, pin functions out
);
  logic [P6M_WAIT_REGIONS-1:0] region_ext; // region picks external wait
  logic strb_mode; // extension mode with strobes
  logic addr2; // first address pair assigned
  logic addr4; // both address pairs assigned

  // one decode per wait region
  genvar g;
  generate
    for (g = 0; g < P6M_WAIT_REGIONS; g++) begin : g_region
      assign region_ext[g] = (s.wait_ctrl[2*g+1 -: 2] == P6M_WAIT_EXT); // [R7]
    end
  endgenerate

  // mode decode; codes above the last legal one act as port mode
  assign strb_mode = (s.mode >= P6M_MM_STRB_MIN) && (s.mode <= P6M_MM_ADDR4); // [R4]
  assign addr2 = (s.mode == P6M_MM_ADDR2) || (s.mode == P6M_MM_ADDR4); // [R2]
  assign addr4 = (s.mode == P6M_MM_ADDR4); // [R2]

  // per-pin control ownership, enable and value
  always_comb begin
    s.ctrl_mask = 8'h00;
    s.ctrl_oe = 8'h00;
    s.ctrl_val = 8'h00;
    s.wait_en = 1'b0;
    // upper address lines, driven only for extended space
    for (int i = 0; i < 2 * P6M_ADDR_PAIR; i++) begin
      if ((i < P6M_ADDR_PAIR) ? addr2 : addr4) begin
        s.ctrl_mask[i] = !s.reduced; // reduced keeps 0-3 as port [R13]
        s.ctrl_oe[i] = !s.reduced && s.ext_space; // [R3]
        s.ctrl_val[i] = s.addr_hi[i]; // [R3]
      end
    end
    // strobes, active low, fixed on in the reduced variant
    if (strb_mode || s.reduced) begin
      s.ctrl_mask[P6M_PIN_RD] = 1'b1; // [R4] [R13]
      s.ctrl_mask[P6M_PIN_WR] = 1'b1; // [R4] [R13]
      s.ctrl_oe[P6M_PIN_RD] = 1'b1;
      s.ctrl_oe[P6M_PIN_WR] = 1'b1;
      s.ctrl_val[P6M_PIN_RD] = !s.ext_rd; // [R5]
      s.ctrl_val[P6M_PIN_WR] = !s.ext_wr; // [R6]
    end
    // pin 6: hold request wins over wait input
    if (s.hold_en) begin
      s.ctrl_mask[P6M_PIN_IN] = 1'b1; // [R8]
    end else if ((|region_ext) && s.dir[P6M_PIN_IN]) begin
      s.ctrl_mask[P6M_PIN_IN] = 1'b1; // [R7]
      s.wait_en = 1'b1; // [R7]
    end
    // pin 7: hold acknowledge wins over refresh
    if (s.hold_en) begin
      s.ctrl_mask[P6M_PIN_OUT] = 1'b1; // [R9]
      s.ctrl_oe[P6M_PIN_OUT] = 1'b1;
      s.ctrl_val[P6M_PIN_OUT] = s.hold_ack; // [R9]
    end else if (s.refr_en) begin
      s.ctrl_mask[P6M_PIN_OUT] = 1'b1; // [R10]
      s.ctrl_oe[P6M_PIN_OUT] = 1'b1;
      s.ctrl_val[P6M_PIN_OUT] = s.refr_pulse; // [R10]
    end
  end
endmodule

// *** verification/p6m_ext_model.sv ***
`timescale 1ns/1ps
// far side of the port: external drivers, device pull-ups and floating lines of the board wiring
module p6m_ext_model (
  input wire logic clk_i, // system clock
  input wire logic [7:0] pins_o_i, // device drive values
  input wire logic [7:0] pins_oe_i, // device drive enables
  input wire logic [7:0] pullup_i, // device pull-up enables
  input wire logic [7:0] drv_en_i, // far side drives this pin
  input wire logic [7:0] drv_val_i, // far side drive value
  output logic [7:0] level_o // resolved pin level
);
  logic [7:0] last = 8'h00; // level seen in the previous cycle
  // resolve each wire; a floating line flips every cycle so it never looks stable
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pins_oe_i[i]) begin
        level_o[i] = pins_o_i[i]; // device drives the pin
      end else if (drv_en_i[i]) begin
        level_o[i] = drv_val_i[i]; // far side drives the pin: port input, wait or hold request
      end else if (pullup_i[i]) begin
        level_o[i] = 1'b1; // pulled up
      end else begin
        level_o[i] = ~last[i]; // released line
      end
    end
  end
  // remember the level for the floating case
  always_ff @(posedge clk_i) begin
    last <= level_o;
  end
endmodule

// *** verification/p6m_port_tb.sv ***
`timescale 1ns/1ps
// register-level test of the port, its control functions and the reduced variant
module p6m_port_tb;
  import p6m_pkg::*;
  logic clk_i = 1'b0; // system clock
  logic rst_i = 1'b1; // reset
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // bus request
  logic [7:0] adr = 8'h00; // bus address
  logic [3:0] sel = 4'hF; // byte selects
  logic [31:0] dw = 32'h0; // write data
  logic [31:0] dat_o; // read data
  logic ack; // acknowledge
  logic ext_space = 1'b0, ext_rd = 1'b0, ext_wr = 1'b0; // external access state
  logic [3:0] addr_hi = 4'h0; // upper address bits
  logic hold_ack = 1'b0, refr = 1'b0; // pin 7 sources
  logic hreq, wt; // synced pin 6 functions
  logic [7:0] pins_i, pins_o, oe, pu, pins_o_r, oe_r; // pin sides
  logic [7:0] drv_en = 8'h00, drv_val = 8'h00; // far side drive
  int errors = 0, compares = 0, cycles = 0; // counters
  // 20 MHz clock
  always #25 clk_i = ~clk_i;
  p6m_port DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .ext_space_i(ext_space), .ext_addr_hi_i(addr_hi), .ext_rd_i(ext_rd), .ext_wr_i(ext_wr),
    .hold_ack_i(hold_ack), .refresh_pulse_i(refr), .bus_hold_request_o(hreq),
    .ext_wait_o(wt), .port_pins_i(pins_i), .port_pins_o(pins_o), .port_pins_oe_o(oe),
    .port_pullup_o(pu));
  // reduced variant shares bus and pins; only its pin drive is judged
  p6m_port #(.REDUCED_VARIANT(1'b1)) DUT_R (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
    .wb_dat_o(), .wb_ack_o(), .ext_space_i(ext_space), .ext_addr_hi_i(addr_hi),
    .ext_rd_i(ext_rd), .ext_wr_i(ext_wr), .hold_ack_i(hold_ack), .refresh_pulse_i(refr),
    .bus_hold_request_o(), .ext_wait_o(), .port_pins_i(pins_i), .port_pins_o(pins_o_r),
    .port_pins_oe_o(oe_r), .port_pullup_o());
  p6m_ext_model u_ext (.clk_i(clk_i), .pins_o_i(pins_o), .pins_oe_i(oe), .pullup_i(pu),
    .drv_en_i(drv_en), .drv_val_i(drv_val), .level_o(pins_i));
  // compare and report
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one classic wishbone cycle, held until ack is sampled
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
    output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    logic [31:0] q;
    xfer(a, 1'b0, 8'h00, q);
    chk(nm, {24'h0, exp}, q);
  endtask
  // let pins and synchronisers catch up
  task automatic settle;
    repeat (4) @(posedge clk_i);
    #1;
  endtask
  task automatic test_done;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      test_done();
    end
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("oe in reset", 8'h00, oe);
    chk("reduced oe in reset", 4'h0, oe_r[3:0]);
    settle();
    chk("reduced low pins oe", 4'hF, oe_r[3:0]);
    chk("reduced low pins val", 4'h0, pins_o_r[3:0]);
    chk("reduced strobes oe", 2'h3, oe_r[5:4]);
    rd(P6M_OFF_DIR, P6M_DIR_RST, "dir reset");
    rd(P6M_OFF_MODE, 8'h00, "mode reset");
    rd(8'h20, 8'h00, "unmapped read");
    sel <= 4'hE;
    wr(P6M_OFF_DIR, 8'h00);
    sel <= 4'hF;
    rd(P6M_OFF_DIR, P6M_DIR_RST, "dir sel refused");
    $display("test reset done");
    wr(P6M_OFF_DATA, 8'hA5);
    wr(P6M_OFF_DIR, 8'h0F);
    @(posedge clk_i);
    drv_en <= 8'h0F;
    drv_val <= 8'h06;
    wr(P6M_OFF_PUO, 8'h40);
    settle();
    chk("oe by dir", 8'hF0, oe);
    chk("high latch out", 4'hA, pins_o[7:4]);
    chk("pull-ups on inputs", 8'h0F, pu);
    chk("reduced output-only", 4'hF, oe_r[3:0]);
    rd(P6M_OFF_DATA, 8'hA6, "mixed read");
    @(posedge clk_i);
    drv_en <= 8'h00;
    wr(P6M_OFF_DIR, 8'h00);
    settle();
    chk("latch kept for inputs", 8'hA5, pins_o);
    chk("no pull-ups on outputs", 8'h00, pu);
    $display("test port done");
    wr(P6M_OFF_MODE, P6M_MM_STRB_MIN);
    @(posedge clk_i);
    ext_rd <= 1'b1;
    settle();
    chk("read strobe", 2'b10, pins_o[5:4]);
    @(posedge clk_i);
    ext_rd <= 1'b0;
    ext_wr <= 1'b1;
    settle();
    chk("write strobe", 2'b01, pins_o[5:4]);
    wr(P6M_OFF_DATA, 8'h00);
    rd(P6M_OFF_DATA, 8'h00, "strobe pins hidden");
    wr(P6M_OFF_DATA, 8'hA5);
    rd(P6M_OFF_DATA, 8'h85, "strobe pins masked");
    @(posedge clk_i);
    ext_wr <= 1'b0;
    ext_space <= 1'b1;
    addr_hi <= 4'hA;
    wr(P6M_OFF_MODE, P6M_MM_ADDR2);
    settle();
    chk("two address lines", 4'h6, pins_o[3:0]);
    chk("strobes idle high", 2'b11, pins_o[5:4]);
    wr(P6M_OFF_MODE, P6M_MM_ADDR4);
    settle();
    chk("four address lines", 4'hA, pins_o[3:0]);
    chk("reduced no address", 4'h5, pins_o_r[3:0]);
    @(posedge clk_i);
    ext_space <= 1'b0;
    settle();
    chk("address float internal", 4'h0, oe[3:0]);
    wr(P6M_OFF_MODE, P6M_MODE_RST);
    settle();
    chk("port mode again", 8'hFF, oe);
    $display("test extension done");
    wr(P6M_OFF_DIR, 8'hC0);
    wr(P6M_OFF_HOLD, 8'h01);
    @(posedge clk_i);
    drv_en <= 8'h40;
    drv_val <= 8'h40;
    hold_ack <= 1'b1;
    settle();
    chk("hold request", 1'b1, hreq);
    chk("hold ack pin", 2'b11, {oe[7], pins_o[7]});
    rd(P6M_OFF_DATA, 8'h25, "hold pins hidden");
    wr(P6M_OFF_HOLD, 8'h00);
    wr(P6M_OFF_REFR, 8'h01);
    @(posedge clk_i);
    refr <= 1'b1;
    settle();
    chk("hold request off", 1'b0, hreq);
    chk("refresh high", 2'b11, {oe[7], pins_o[7]});
    @(posedge clk_i);
    refr <= 1'b0;
    settle();
    chk("refresh low", 2'b10, {oe[7], pins_o[7]});
    wr(P6M_OFF_REFR, 8'h00);
    $display("test hold refresh done");
    @(posedge clk_i);
    drv_val <= 8'h00;
    settle();
    chk("wait unused", 1'b0, wt);
    wr(P6M_OFF_WAITA, 8'h03);
    settle();
    chk("wait asserted", 1'b1, wt);
    @(posedge clk_i);
    drv_val <= 8'h40;
    settle();
    chk("wait released", 1'b0, wt);
    $display("test wait done");
    test_done();
  end
endmodule
